// File: fan_ramp_pkg.sv
package fan_ramp_pkg;

	// Register offsets
	localparam logic [7:0] FAN1_MIN_DUTY_ADDR = 8'h64;
	localparam logic [7:0] FAN2_MIN_DUTY_ADDR = 8'h65;
	localparam logic [7:0] FAN3_MIN_DUTY_ADDR = 8'h66;
	localparam logic [7:0] ACOUSTIC_SMOOTH_ADDR = 8'h5f;

	// Reset values
	localparam logic [7:0] MIN_DUTY_RESET = 8'h80;
	localparam logic [2:0] RAMP_CODE_RESET = 3'h0;
	localparam logic SMOOTH_EN_RESET = 1'b0;

	// Acoustic smoothing register field positions
	localparam int SMOOTH_EN_BIT = 7;
	localparam int RAMP_CODE_MSB = 6;
	localparam int RAMP_CODE_LSB = 4;

	// Ramp code to time-slot count
	localparam logic [7:0] SLOT_TAB [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
		8'h08, 8'h0c, 8'h18, 8'h30};

	// Full-range ramp times at one time slot, in milliseconds
	localparam longint unsigned RAMP_FAST_MS = 64'd37500;
	localparam longint unsigned RAMP_SLOW_MS = 64'd52200;

	// Clock rate and number of duty codes crossed by a full ramp
	localparam longint unsigned CLK_PER_MS = 64'd100000;
	localparam longint unsigned FULL_SCALE_STEPS = 64'd255;

	// One duty code per step at one slot; rounded down (a longest time)
	localparam longint unsigned STEP_FAST_CYC = RAMP_FAST_MS * CLK_PER_MS / FULL_SCALE_STEPS;
	localparam longint unsigned STEP_SLOW_CYC = RAMP_SLOW_MS * CLK_PER_MS / FULL_SCALE_STEPS;

	// PWM frame: counter runs 0..254 so code 0xff is always on
	localparam logic [7:0] PWM_LAST_COUNT = 8'hfe;
	localparam int NUM_FANS = 3;

endpackage

// File: fan_ramp_limiter.sv
`timescale 1ns/1ps

// One fan output: steers applied duty toward its target
module fan_ramp_limiter
	import fan_ramp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] target_duty,
	input wire logic smooth_on,
	input wire logic step_tick,
	output logic [7:0] applied_duty
);

	logic [7:0] applied_q; // Duty now driven to the PWM stage
	logic [7:0] applied_d;

	// Next applied duty
	always_comb
	begin
		applied_d = applied_q;
		if (!smooth_on)
		begin
			// No smoothing: jump straight to target
			applied_d = target_duty;
		end
		else if (target_duty < applied_q)
		begin
			// Only rises are rate limited; falls take effect at once
			applied_d = target_duty;
		end
		else if (step_tick && (target_duty > applied_q))
		begin
			// One code per step period, never past target
			applied_d = applied_q + 8'h01;
		end
	end

	// Applied duty register
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			applied_q <= 8'h00;
		else
			applied_q <= applied_d;
	end

	assign applied_duty = applied_q;

endmodule

// File: fan_pwm_ramp_and_min_duty.sv
`timescale 1ns/1ps

// Function
// - Smoothing limits duty rise, ramps toward target
// - Fast mode: codes select slots 1..48
// - Slow mode: same codes, longer ramp times
// - Enable bit 7 smooths Remote 2 outputs
// - Lock bit makes smoothing register read-only
// - Three min duty registers reset 0x80
// - Min duty maps linearly, 0xFF full on
// - Auto mode makes min duty registers read-only
// - Bits 6:4 hold Remote 2 ramp code
// - Above threshold, target never below minimum duty
module fan_pwm_ramp_and_min_duty
	import fan_ramp_pkg::*;
#(
	parameter int unsigned STEP_FAST_CYCLES = 32'(STEP_FAST_CYC), // Cycles per step, one slot
	parameter int unsigned STEP_SLOW_CYCLES = 32'(STEP_SLOW_CYC)
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic slow_ramp,
	input wire logic config_lock,
	input wire logic auto_mode,
	input wire logic [2:0] remote2_assoc,
	input wire logic [2:0] above_tmin,
	input wire logic [7:0] target_duty_one,
	input wire logic [7:0] target_duty_two,
	input wire logic [7:0] target_duty_three,
	output logic fan_drive_one,
	output logic fan_drive_two,
	output logic fan_drive_three,
	output logic [7:0] applied_duty_one,
	output logic [7:0] applied_duty_two,
	output logic [7:0] applied_duty_three
);

	logic [7:0] min_duty_q [NUM_FANS]; // Minimum duty per fan output
	logic remote2_smooth_enable_q; // Smoothing enable
	logic [2:0] remote2_ramp_rate_q; // Ramp code
	logic [7:0] reg_rdata_q; // Registered read data
	logic [31:0] step_fast_tab [8]; // Step period per code, fast mode
	logic [31:0] step_slow_tab [8]; // Step period per code, slow mode
	logic [31:0] step_period; // Selected step period
	logic [31:0] step_cnt_q; // Step timer
	logic step_tick_q; // One-cycle pulse per step period
	logic [2:0] ramp_code_last_q; // Code seen last cycle
	logic slow_last_q; // Slow bit seen last cycle
	logic [7:0] target_in [NUM_FANS]; // Targets as an array
	logic [7:0] target_eff [NUM_FANS]; // Target after minimum duty floor
	logic [7:0] applied [NUM_FANS]; // Limiter outputs
	logic [7:0] pwm_cnt_q; // PWM frame counter
	logic [NUM_FANS-1:0] drive_q; // PWM outputs

	// Targets gathered into an array so the per-fan loop can index them
	assign target_in[0] = target_duty_one;
	assign target_in[1] = target_duty_two;
	assign target_in[2] = target_duty_three;

	// Minimum duty registers; writes dropped in automatic mode
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			min_duty_q[0] <= MIN_DUTY_RESET;
			min_duty_q[1] <= MIN_DUTY_RESET;
			min_duty_q[2] <= MIN_DUTY_RESET;
		end
		else if (reg_wr && !auto_mode)
		begin
			if (reg_addr == FAN1_MIN_DUTY_ADDR)
				min_duty_q[0] <= reg_wdata;
			if (reg_addr == FAN2_MIN_DUTY_ADDR)
				min_duty_q[1] <= reg_wdata;
			if (reg_addr == FAN3_MIN_DUTY_ADDR)
				min_duty_q[2] <= reg_wdata;
		end
	end

	// Acoustic smoothing register; frozen once the lock is set
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			remote2_smooth_enable_q <= SMOOTH_EN_RESET;
			remote2_ramp_rate_q <= RAMP_CODE_RESET;
		end
		else if (reg_wr && !config_lock && (reg_addr == ACOUSTIC_SMOOTH_ADDR))
		begin
			remote2_smooth_enable_q <= reg_wdata[SMOOTH_EN_BIT];
			remote2_ramp_rate_q <= reg_wdata[RAMP_CODE_MSB:RAMP_CODE_LSB];
		end
	end

	// Read data, registered; unused bits and unmapped addresses read zero
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			reg_rdata_q <= 8'h00;
		else
		begin
			unique case (reg_addr)
				FAN1_MIN_DUTY_ADDR:
					reg_rdata_q <= min_duty_q[0];
				FAN2_MIN_DUTY_ADDR:
					reg_rdata_q <= min_duty_q[1];
				FAN3_MIN_DUTY_ADDR:
					reg_rdata_q <= min_duty_q[2];
				ACOUSTIC_SMOOTH_ADDR:
					reg_rdata_q <= {remote2_smooth_enable_q, remote2_ramp_rate_q, 4'h0};
				default:
					reg_rdata_q <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = reg_rdata_q;

	// Step period per code: base step shared out over the slot count
	for (genvar i = 0; i < 8; i++)
	begin : g_step_tab
		// Constant division, folded at elaboration rather than built
		assign step_fast_tab[i] = 32'(STEP_FAST_CYCLES / 32'(SLOT_TAB[i]));
		assign step_slow_tab[i] = 32'(STEP_SLOW_CYCLES / 32'(SLOT_TAB[i]));
	end

	// Slow bit selects the longer table
	always_comb
	begin
		if (slow_ramp)
			step_period = step_slow_tab[remote2_ramp_rate_q];
		else
			step_period = step_fast_tab[remote2_ramp_rate_q];
	end

	// Step timer; restarts when code or mode changes so a new
	// rate never inherits a half-spent long period
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			step_cnt_q <= 32'h0000_0000;
			step_tick_q <= 1'b0;
			ramp_code_last_q <= RAMP_CODE_RESET;
			slow_last_q <= 1'b0;
		end
		else
		begin
			ramp_code_last_q <= remote2_ramp_rate_q;
			slow_last_q <= slow_ramp;
			if ((ramp_code_last_q != remote2_ramp_rate_q) || (slow_last_q != slow_ramp))
			begin
				step_cnt_q <= 32'h0000_0000;
				step_tick_q <= 1'b0;
			end
			else if ((step_cnt_q + 32'h0000_0001) >= step_period)
			begin
				step_cnt_q <= 32'h0000_0000;
				step_tick_q <= 1'b1;
			end
			else
			begin
				step_cnt_q <= step_cnt_q + 32'h0000_0001;
				step_tick_q <= 1'b0;
			end
		end
	end

	// Per fan: floor, limiter, PWM compare
	for (genvar i = 0; i < NUM_FANS; i++)
	begin : g_fan
		// Below threshold the output is off; above it the target is never under minimum
		assign target_eff[i] = !above_tmin[i] ? 8'h00 :
			((target_in[i] < min_duty_q[i]) ? min_duty_q[i] : target_in[i]);

		fan_ramp_limiter u_limiter (
			.clk(clk),
			.rst_b(rst_b),
			.target_duty(target_eff[i]),
			.smooth_on(remote2_smooth_enable_q && remote2_assoc[i]),
			.step_tick(step_tick_q),
			.applied_duty(applied[i])
		);

		// Counter spans 0..254: 0x00 never on, 0xff always on
		always_ff @(posedge clk)
		begin
			if (!rst_b)
				drive_q[i] <= 1'b0;
			else
				drive_q[i] <= (pwm_cnt_q < applied[i]);
		end
	end

	// PWM frame counter, 255 clocks per frame
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			pwm_cnt_q <= 8'h00;
		else if (pwm_cnt_q == PWM_LAST_COUNT)
			pwm_cnt_q <= 8'h00;
		else
			pwm_cnt_q <= pwm_cnt_q + 8'h01;
	end

	// Outputs come straight from their flops; no logic after the registers
	// keeps the pins glitch free
	assign fan_drive_one = drive_q[0];
	assign fan_drive_two = drive_q[1];
	assign fan_drive_three = drive_q[2];
	// Applied duty is the limiter's own register
	assign applied_duty_one = applied[0];
	assign applied_duty_two = applied[1];
	assign applied_duty_three = applied[2];

endmodule

// File: fan_model.sv
`timescale 1ns/1ps

// Fan stand-in: counts drive-high clocks over each 255-clock window
module fan_model
(
	input wire logic clk,
	input wire logic drive,
	output logic [7:0] seen_duty
);
	logic [7:0] win_q = 8'h00; // Window position
	logic [7:0] high_q = 8'h00; // High clocks so far

	// Free-running window; a steady frame gives the exact count at any phase
	always @(posedge clk)
	begin
		win_q <= (win_q == 8'hfe) ? 8'h00 : win_q + 8'h01;
		high_q <= (win_q == 8'hfe) ? 8'h00 : high_q + 8'(drive);
		if (win_q == 8'hfe)
			seen_duty <= high_q + 8'(drive);
	end
endmodule

// File: fan_ramp_chk.sv
`timescale 1ns/1ps

module fan_ramp_chk
	import fan_ramp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic config_lock,
	input wire logic auto_mode,
	input wire logic [2:0] remote2_assoc,
	input wire logic [2:0] above_tmin,
	input wire logic [7:0] target_duty_two,
	input wire logic fan_drive_one,
	input wire logic [7:0] applied_duty_one,
	input wire logic [7:0] applied_duty_two
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// Guarded address held with its guard up
	sequence s_lock;
		(config_lock && reg_addr == ACOUSTIC_SMOOTH_ADDR)[*3];
	endsequence
	sequence s_auto;
		(auto_mode && reg_addr == FAN1_MIN_DUTY_ADDR)[*3];
	endsequence

	a_reset_clear: assert property (disable iff (1'b0) !rst_b |=>
		reg_rdata == 8'h00 && applied_duty_one == 8'h00)
		else $error("outputs not clear after reset");
	a_lock_keeps: assert property (s_lock |-> $stable(reg_rdata))
		else $error("locked smoothing register changed");
	a_auto_keeps: assert property (s_auto |-> $stable(reg_rdata))
		else $error("min duty changed in auto mode");
	a_unmapped_zero: assert property ((reg_addr < ACOUSTIC_SMOOTH_ADDR)[*2]
		|-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_below_off: assert property (!above_tmin[0] [*2] |-> applied_duty_one == 8'h00)
		else $error("fan on below threshold");
	a_drive_off: assert property ($past(applied_duty_one) == 8'h00 |-> !fan_drive_one)
		else $error("drive high at zero duty");
	a_drive_full: assert property ($past(rst_b) && $past(applied_duty_one) == 8'hff
		|-> fan_drive_one)
		else $error("drive low at full duty");
	a_unassoc_jump: assert property ((above_tmin[1] && !remote2_assoc[1]
		&& target_duty_two == 8'hff)[*2] |-> applied_duty_two == 8'hff)
		else $error("unsmoothed fan did not jump");
endmodule

bind fan_pwm_ramp_and_min_duty fan_ramp_chk u_chk (.clk, .rst_b, .reg_addr, .reg_rdata,
	.config_lock, .auto_mode, .remote2_assoc, .above_tmin, .target_duty_two, .fan_drive_one,
	.applied_duty_one, .applied_duty_two);

// File: fan_pwm_ramp_and_min_duty_tb.sv
`timescale 1ns/1ps

module fan_pwm_ramp_and_min_duty_tb;
	import fan_ramp_pkg::*;
	localparam int unsigned FAST = 960; // Short steps, divisible by every slot count
	localparam int unsigned SLOW = 1440;
	typedef struct {int sel; logic [7:0] exp;} note_t;
	logic clk = 0, rst_b = 0, reg_wr = 0, slow_ramp = 0, config_lock = 0, auto_mode = 0, chk = 0;
	logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, t1 = '0, t2 = '0, t3 = '0;
	logic [2:0] remote2_assoc = '0, above_tmin = '0;
	wire logic [2:0] drv; // Fan drive pins, one port per bit
	logic [7:0] a1, a2, a3, s1, s2, s3;
	logic [7:0] obs [7]; // Outputs by note index
	note_t q [$]; // Expected results, oldest first
	note_t n;
	int errors = 0, cmp_count = 0, cyc = 0;
	string nm [7] = '{"rdata", "seen1", "seen2", "seen3", "app1", "app2", "app3"};

	fan_pwm_ramp_and_min_duty #(.STEP_FAST_CYCLES(FAST), .STEP_SLOW_CYCLES(SLOW)) u_dut (.clk,
		.rst_b, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .slow_ramp, .config_lock,
		.auto_mode, .remote2_assoc, .above_tmin, .target_duty_one(t1), .target_duty_two(t2),
		.target_duty_three(t3), .fan_drive_one(drv[0]), .fan_drive_two(drv[1]),
		.fan_drive_three(drv[2]), .applied_duty_one(a1), .applied_duty_two(a2),
		.applied_duty_three(a3));
	fan_model u_f1 (.clk, .drive(drv[0]), .seen_duty(s1));
	fan_model u_f2 (.clk, .drive(drv[1]), .seen_duty(s2));
	fan_model u_f3 (.clk, .drive(drv[2]), .seen_duty(s3));

	always_comb obs = '{reg_rdata, s1, s2, s3, a1, a2, a3};

	// Clock
	initial
	begin
		forever #5 clk = ~clk;
	end

	task automatic test_done();
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watcher: oldest note against the output it names; also the hang limit
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			errors++;
			test_done();
		end
		else if (chk)
		begin
			n = q.pop_front();
			cmp_count++;
			if (obs[n.sel] !== n.exp)
			begin
				errors++;
				$display("mismatch %s exp %h got %h", nm[n.sel], n.exp, obs[n.sel]);
			end
		end
	end

	// Write leaves one idle edge so the strobe is never set twice at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic see(input int s, input logic [7:0] e);
		@(posedge clk);
		q.push_back('{s, e});
		chk <= 1'b1;
		@(posedge clk);
		chk <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		repeat (2) @(posedge clk);
		see(0, e);
	endtask

	initial
	begin
		logic s, r;
		int p;
		void'($urandom(32'hf7c8_7e36));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 3; i++)
			rd(FAN1_MIN_DUTY_ADDR + 8'(i), MIN_DUTY_RESET);
		rd(ACOUSTIC_SMOOTH_ADDR, 8'h00);
		rd(8'h10, 8'h00);
		// Floors of quarter, full and off; fan three follows a random target
		wr(FAN1_MIN_DUTY_ADDR, 8'h40);
		wr(FAN2_MIN_DUTY_ADDR, 8'hff);
		wr(FAN3_MIN_DUTY_ADDR, 8'h00);
		rd(FAN1_MIN_DUTY_ADDR, 8'h40);
		t3 <= 8'($urandom);
		above_tmin <= 3'b111;
		repeat (600) @(posedge clk);
		see(1, 8'h40);
		see(2, 8'hff);
		see(3, t3);
		see(4, 8'h40);
		see(6, t3);
		auto_mode <= 1'b1;
		wr(FAN1_MIN_DUTY_ADDR, 8'h11);
		rd(FAN1_MIN_DUTY_ADDR, 8'h40);
		auto_mode <= 1'b0;
		// Every code, speeds alternating: fall to zero, then one code per step
		remote2_assoc <= 3'b001;
		t1 <= 8'hff;
		t2 <= 8'hff;
		r = 1'($urandom);
		for (int c = 7; c >= 0; c--)
		begin
			// Code written with fan one held off, so the ramp starts at zero
			// from a freshly restarted step timer
			s = 1'(c) ^ r;
			above_tmin <= 3'b110;
			slow_ramp <= s;
			wr(ACOUSTIC_SMOOTH_ADDR, {1'b1, 3'(c), 4'h0});
			repeat (2) @(posedge clk);
			above_tmin <= 3'b111;
			p = (s ? SLOW : FAST) / SLOT_TAB[c];
			repeat (p * 7 / 2) @(posedge clk);
			see(4, 8'h03);
		end
		see(5, 8'hff);
		// Smoothing off, then a locked write that would turn it on
		wr(ACOUSTIC_SMOOTH_ADDR, 8'h7f);
		rd(ACOUSTIC_SMOOTH_ADDR, 8'h70);
		config_lock <= 1'b1;
		wr(ACOUSTIC_SMOOTH_ADDR, 8'hff);
		rd(ACOUSTIC_SMOOTH_ADDR, 8'h70);
		see(4, 8'hff);
		test_done();
	end
endmodule
